// >>> rtl/sfpc_defines.vh
// Constants of the transceiver sideband control block
`ifndef SFPC_DEFINES_VH
`define SFPC_DEFINES_VH

// Clock rate
`define SFPC_CLK_MHZ          20
`define SFPC_CLK_HZ           20000000

// Register word offsets
`define SFPC_OFS_CONTROL      4'h0
`define SFPC_OFS_STATUS       4'h1
`define SFPC_OFS_IRQ_STATUS   4'h2
`define SFPC_OFS_IRQ_MASK     4'h3
`define SFPC_OFS_IDENT        4'h4
`define SFPC_OFS_DIAG         4'h5

// Control fields
`define SFPC_CTL_RX_RATE      0
`define SFPC_CTL_TX_RATE      1
`define SFPC_CTL_HIGH_POWER   2
`define SFPC_CTL_RESET        3'h0

// Status fields
`define SFPC_ST_LASER_OFF     0
`define SFPC_ST_RX_RATE       1
`define SFPC_ST_TX_RATE       2
`define SFPC_ST_CDR_WORKING   3
`define SFPC_ST_FAULT         4
`define SFPC_ST_SIGNAL_LOST   5
`define SFPC_ST_MGMT_READY    6
`define SFPC_ST_MODULE_READY  7

// Interrupt fields
`define SFPC_IRQ_FAULT_SET    0
`define SFPC_IRQ_LOS_SET      1
`define SFPC_IRQ_READY        2
`define SFPC_IRQ_FAULT_CLR    3
`define SFPC_IRQ_RESET        4'h0

// Timing figures in their own units
`define SFPC_T_RESET_US       10
`define SFPC_T_MGMT_MS        300
`define SFPC_T_START_MS       300
`define SFPC_T_HIGH_POWER_MS  300
`define SFPC_T_COOLED_S       90

// Timing counts in clock cycles
`define SFPC_RESET_CYC        (`SFPC_T_RESET_US * `SFPC_CLK_MHZ)
`define SFPC_MGMT_CYC         (`SFPC_T_MGMT_MS * `SFPC_CLK_MHZ * 1000)
`define SFPC_START_CYC        (`SFPC_T_START_MS * `SFPC_CLK_MHZ * 1000)
`define SFPC_HIGH_POWER_CYC   (`SFPC_T_HIGH_POWER_MS * `SFPC_CLK_MHZ * 1000)
`define SFPC_COOLED_CYC       (`SFPC_T_COOLED_S * `SFPC_CLK_HZ)

`endif

// >>> rtl/sfpc_sideband.v
// Sideband pin control, start-up timing and register slave of the transceiver
//
// Function
// - Fault flag released to pull-up high on laser fault
// - Laser off unless laser-off input low
// - Receive rate select reads low undriven
// - Transmit rate select reads low undriven
// - OR pins with bits; CDRs work both-high
// - Module-absent contact tied to ground
// - Signal-lost output high on low optical level
// - Identification and diagnostics readable by host
// - Laser off quickly after laser-off rises
// - Laser on within limit after release
// - Management ready within start-up time
// - Uncooled module ready within start-up time
// - Cooled module ready within its limit
// - Uncooled high power ready within limit
// - Long laser-off pulse clears latched fault
// - Fault flag asserted within cooled limit
// - Signal-lost asserted within its limit
// - Rate change settles within limit
//
// The register offsets and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
`include "sfpc_defines.vh"

module sfpc_sideband #(
  parameter        COOLED        = 1,
  parameter [31:0] RESET_CYC     = `SFPC_RESET_CYC,
  parameter [31:0] MGMT_CYC      = `SFPC_MGMT_CYC,
  parameter [31:0] START_CYC     = `SFPC_START_CYC,
  parameter [31:0] HIGH_PWR_CYC  = `SFPC_HIGH_POWER_CYC,
  parameter [31:0] COOLED_CYC    = `SFPC_COOLED_CYC,
  parameter [31:0] IDENT_VALUE   = 32'h0000_5A01
) (
  input  wire        ref_clk,
  input  wire        sys_rst,
  input  wire        laserOffPin,
  input  wire        rx_rate_select,
  input  wire        tx_rate_select,
  input  wire        laserFaultDetect,
  input  wire        rxPowerLow,
  input  wire [15:0] diagValue,
  input  wire [3:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  output wire        laserEnable,
  output wire        rxCdrBypass,
  output wire        txCdrBypass,
  output wire        faultPinOut,
  output wire        faultPinOe,
  output wire        losPinOut,
  output wire        losPinOe,
  output wire        module_absent_pin,
  output wire        mgmtReady,
  output wire        moduleReady,
  output wire        irq
);

  // IDENT_VALUE is an arbitrary identification code

  ////////////////////////////////////////////////////////////////////////////////
  // Input synchronisers

  localparam NSYNC = 5;
  localparam SI_LASER_OFF = 0;
  localparam SI_RX_RATE   = 1;
  localparam SI_TX_RATE   = 2;
  localparam SI_FAULT     = 3;
  localparam SI_POWER_LOW = 4;

  wire [NSYNC-1:0] asyncIn;
  wire [NSYNC-1:0] syncIn;
  // Laser-off resets high so the laser stays dark until the pin is seen low
  wire [NSYNC-1:0] syncReset;

  assign asyncIn   = {rxPowerLow, laserFaultDetect, tx_rate_select, rx_rate_select,
                      laserOffPin};
  assign syncReset = {NSYNC{1'b0}} | {{(NSYNC-1){1'b0}}, 1'b1};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : gSync
      reg stage1;
      reg stage2;
      always @(posedge ref_clk) begin
        if (sys_rst) begin
          stage1 <= syncReset[gi];
          stage2 <= syncReset[gi];
        end else begin
          stage1 <= asyncIn[gi];
          stage2 <= stage1;
        end
      end
      assign syncIn[gi] = stage2;
    end
  endgenerate

  wire laserOff;
  wire rxRatePin;
  wire txRatePin;
  wire faultSeen;
  wire powerLow;

  assign laserOff  = syncIn[SI_LASER_OFF];
  assign rxRatePin = syncIn[SI_RX_RATE];
  assign txRatePin = syncIn[SI_TX_RATE];
  assign faultSeen = syncIn[SI_FAULT];
  assign powerLow  = syncIn[SI_POWER_LOW];

  ////////////////////////////////////////////////////////////////////////////////
  // Avalon-MM slave, one wait state

  reg         busAck;
  reg  [2:0]  control;
  reg  [3:0]  irqStatus;
  reg  [3:0]  irqMask;
  wire        busReq;
  wire        wrStrobe;
  wire [31:0] statusWord;
  reg  [31:0] next_readdata;

  assign busReq          = avs_read | avs_write;
  assign avs_waitrequest = busReq & ~busAck;
  assign wrStrobe        = avs_write & busAck;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      busAck <= 1'b0;
    end else begin
      busAck <= busReq & ~busAck;
    end
  end

  always @* begin
    next_readdata = 32'h0000_0000;
    case (avs_address)
      `SFPC_OFS_CONTROL:    next_readdata = {29'h0000_0000, control};
      `SFPC_OFS_STATUS:     next_readdata = statusWord;
      `SFPC_OFS_IRQ_STATUS: next_readdata = {28'h000_0000, irqStatus};
      `SFPC_OFS_IRQ_MASK:   next_readdata = {28'h000_0000, irqMask};
      `SFPC_OFS_IDENT: begin
        if (mgmtReady) begin
          next_readdata = IDENT_VALUE;
        end
      end
      `SFPC_OFS_DIAG: begin
        if (mgmtReady) begin
          next_readdata = {16'h0000, diagValue};
        end
      end
      default:              next_readdata = 32'h0000_0000;
    endcase
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~busAck) begin
      avs_readdata <= next_readdata;
    end
  end

  // Control and mask registers
  wire highPowerRise;

  assign highPowerRise = wrStrobe & (avs_address == `SFPC_OFS_CONTROL) &
                         avs_writedata[`SFPC_CTL_HIGH_POWER] &
                         ~control[`SFPC_CTL_HIGH_POWER];

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      control <= `SFPC_CTL_RESET;
      irqMask <= `SFPC_IRQ_RESET;
    end else if (wrStrobe) begin
      if (avs_address == `SFPC_OFS_CONTROL) begin
        control <= avs_writedata[2:0];
      end
      if (avs_address == `SFPC_OFS_IRQ_MASK) begin
        irqMask <= avs_writedata[3:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Rate select and clock recovery

  wire rxRateOr;
  wire txRateOr;
  wire cdrWorking;

  assign rxRateOr   = rxRatePin | control[`SFPC_CTL_RX_RATE];
  assign txRateOr   = txRatePin | control[`SFPC_CTL_TX_RATE];
  assign cdrWorking = rxRateOr & txRateOr;
  assign rxCdrBypass = ~cdrWorking;
  assign txCdrBypass = ~cdrWorking;

  ////////////////////////////////////////////////////////////////////////////////
  // Laser fault latch and reset by a long laser-off pulse

  reg        faultFlag;
  reg [31:0] offHeld;
  wire       faultClear;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      offHeld <= 32'h0000_0000;
    end else if (!laserOff) begin
      offHeld <= 32'h0000_0000;
    end else if (offHeld < RESET_CYC) begin
      offHeld <= offHeld + 32'h0000_0001;
    end
  end

  assign faultClear = laserOff & (offHeld >= RESET_CYC);

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      faultFlag <= 1'b0;
    end else if (faultSeen) begin
      faultFlag <= 1'b1;
    end else if (faultClear) begin
      faultFlag <= 1'b0;
    end
  end

  // Open-drain pins: enable pulls the line low, pull-up gives the high level
  assign faultPinOut = 1'b0;
  assign faultPinOe  = ~faultFlag;
  assign losPinOut   = 1'b0;
  assign losPinOe    = ~powerLow;
  assign module_absent_pin = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Start-up timers

  reg        mgmtDone;
  reg [31:0] mgmtCount;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      mgmtCount <= 32'h0000_0000;
      mgmtDone  <= 1'b0;
    end else if (!mgmtDone) begin
      mgmtCount <= mgmtCount + 32'h0000_0001;
      if (mgmtCount >= MGMT_CYC - 32'h0000_0001) begin
        mgmtDone <= 1'b1;
      end
    end
  end

  assign mgmtReady = mgmtDone;

  localparam ST_WAIT  = 2'h0;
  localparam ST_READY = 2'h1;
  localparam [31:0] START_TARGET = (COOLED != 0) ? COOLED_CYC : START_CYC;

  reg  [1:0]  upState;
  reg  [31:0] upCount;
  reg  [31:0] upTarget;
  reg         faultPrev;
  wire        restartUp;
  wire        recovered;
  wire [31:0] normalTarget;
  wire [31:0] powerTarget;

  assign recovered    = faultPrev & ~faultFlag;
  assign normalTarget = START_TARGET;
  assign powerTarget  = (COOLED != 0) ? COOLED_CYC : HIGH_PWR_CYC;
  assign restartUp    = highPowerRise | recovered;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      faultPrev <= 1'b0;
    end else begin
      faultPrev <= faultFlag;
    end
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      upState  <= ST_WAIT;
      upCount  <= 32'h0000_0000;
      upTarget <= START_TARGET;
    end else if (restartUp) begin
      upState  <= ST_WAIT;
      upCount  <= 32'h0000_0000;
      upTarget <= highPowerRise ? powerTarget : normalTarget;
    end else begin
      case (upState)
        ST_WAIT: begin
          upCount <= upCount + 32'h0000_0001;
          if (upCount >= upTarget - 32'h0000_0001) begin
            upState <= ST_READY;
          end
        end
        ST_READY: begin
          upCount <= upCount;
        end
        default: begin
          upState <= ST_WAIT;
        end
      endcase
    end
  end

  assign moduleReady = (upState == ST_READY);

  ////////////////////////////////////////////////////////////////////////////////
  // Laser drive

  // Off at once after the synchronised laser-off; on again with no added delay
  assign laserEnable = ~laserOff & ~faultFlag & moduleReady;

  ////////////////////////////////////////////////////////////////////////////////
  // Status and interrupts

  reg powerLowPrev;
  reg readyPrev;

  assign statusWord = {24'h00_0000, moduleReady, mgmtReady, powerLow, faultFlag,
                       cdrWorking, txRatePin, rxRatePin, laserOff};

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      powerLowPrev <= 1'b0;
      readyPrev    <= 1'b0;
    end else begin
      powerLowPrev <= powerLow;
      readyPrev    <= moduleReady;
    end
  end

  wire [3:0] irqEvent;
  wire [3:0] irqClear;

  assign irqEvent = {recovered, moduleReady & ~readyPrev, powerLow & ~powerLowPrev,
                     faultFlag & ~faultPrev};
  assign irqClear = (wrStrobe && avs_address == `SFPC_OFS_IRQ_STATUS) ?
                    avs_writedata[3:0] : 4'h0;

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      irqStatus <= `SFPC_IRQ_RESET;
    end else begin
      irqStatus <= (irqStatus & ~irqClear) | irqEvent;
    end
  end

  assign irq = |(irqStatus & irqMask);

endmodule // sfpc_sideband

// >>> verification/sfpc_sideband_sva.sv
// Port checker of the sideband control block
`timescale 1ns/1ns
module sfpc_sideband_sva #(
  parameter [31:0] MGMT_CYC = 32'h32
) (
  input logic ref_clk,
  input logic sys_rst,
  input logic laserOffPin,
  input logic rx_rate_select,
  input logic tx_rate_select,
  input logic laserFaultDetect,
  input logic rxPowerLow,
  input logic avs_read,
  input logic avs_write,
  input logic avs_waitrequest,
  input logic laserEnable,
  input logic rxCdrBypass,
  input logic txCdrBypass,
  input logic faultPinOut,
  input logic faultPinOe,
  input logic losPinOut,
  input logic losPinOe,
  input logic module_absent_pin,
  input logic mgmtReady,
  input logic moduleReady
);
  logic [31:0] upCycles;
  // Cycles since reset release
  always_ff @(posedge ref_clk) begin
    if (sys_rst) upCycles <= 32'h0;
    else if (upCycles != 32'hFFFFFFFF) upCycles <= upCycles + 32'h1;
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  AST_CDR_PAIR: assert property (rxCdrBypass == txCdrBypass)
    else $error("cdr bypass outputs differ");
  AST_CDR_WORK: assert property ((rx_rate_select && tx_rate_select) [*3] |-> !rxCdrBypass)
    else $error("cdr bypassed with both rate pins high");
  AST_LASER_OFF: assert property (laserOffPin [*3] |-> !laserEnable)
    else $error("laser on while off requested");
  AST_NOT_READY: assert property (!moduleReady |-> !laserEnable)
    else $error("laser on before ready");
  AST_FAULT_SET: assert property (laserFaultDetect [*3] |=> !faultPinOe)
    else $error("fault line not released");
  AST_LOS_SET: assert property (rxPowerLow [*3] |-> !losPinOe)
    else $error("signal lost not shown");
  AST_LOS_CLR: assert property (!rxPowerLow [*3] |-> losPinOe)
    else $error("signal lost shown wrongly");
  AST_GROUND: assert property (!module_absent_pin && !faultPinOut && !losPinOut)
    else $error("pin drive level not low");
  AST_WAIT: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("wait state count wrong");
  AST_MGMT_ON: assert property (upCycles > MGMT_CYC + 32'h3 |-> mgmtReady)
    else $error("management not ready in time");
  AST_MGMT_HOLD: assert property (mgmtReady |=> mgmtReady)
    else $error("management ready dropped");
endmodule // sfpc_sideband_sva
bind sfpc_sideband sfpc_sideband_sva #(.MGMT_CYC(MGMT_CYC)) i_sfpc_sideband_sva (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .laserOffPin(laserOffPin),
  .rx_rate_select(rx_rate_select), .tx_rate_select(tx_rate_select),
  .laserFaultDetect(laserFaultDetect), .rxPowerLow(rxPowerLow), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .laserEnable(laserEnable),
  .rxCdrBypass(rxCdrBypass), .txCdrBypass(txCdrBypass), .faultPinOut(faultPinOut),
  .faultPinOe(faultPinOe), .losPinOut(losPinOut), .losPinOe(losPinOe),
  .module_absent_pin(module_absent_pin), .mgmtReady(mgmtReady), .moduleReady(moduleReady));

// >>> verification/sfpc_host_model.sv
// Host board model: drives sideband pins, pulls up the open-drain lines
`timescale 1ns/1ns
module sfpc_host_model #(
  parameter [31:0] HOLD = 32'h18
) (
  input  wire logic ref_clk,
  input  wire logic offReq,
  input  wire logic clearReq,
  input  wire logic rxReq,
  input  wire logic txReq,
  input  wire logic faultPinOut,
  input  wire logic faultPinOe,
  input  wire logic losPinOut,
  input  wire logic losPinOe,
  input  wire logic module_absent_pin,
  output logic      laserOffPin,
  output logic      rx_rate_select,
  output logic      tx_rate_select,
  output wire logic faultLine,
  output wire logic losLine,
  output wire logic absentLine
);
  logic [31:0] holdCnt = 32'h0;
  initial begin
    laserOffPin = 1'b1;
    rx_rate_select = 1'b0;
    tx_rate_select = 1'b0;
  end
  // Pull-ups win wherever nothing pulls low
  assign faultLine = faultPinOe ? faultPinOut : 1'b1;
  assign losLine = losPinOe ? losPinOut : 1'b1;
  assign absentLine = (module_absent_pin === 1'b0) ? 1'b0 : 1'b1;
  // Clear request holds laser-off for the full reset time
  always @(posedge ref_clk) begin
    if (clearReq) holdCnt <= HOLD;
    else if (holdCnt != 32'h0) holdCnt <= holdCnt - 32'h1;
    laserOffPin <= offReq | clearReq | (holdCnt != 32'h0);
    rx_rate_select <= rxReq;
    tx_rate_select <= txReq;
  end
endmodule // sfpc_host_model

// >>> verification/test_sfpc_sideband.sv
// Self-checking bench of the sideband control block
`timescale 1ns/1ns
`include "sfpc_defines.vh"
module test_sfpc_sideband;
  localparam [31:0] RST_C = 32'h14;
  localparam [31:0] ID_VAL = 32'h00003C77; // Arbitrary identity value
  logic ref_clk = 1'b0, sys_rst = 1'b1, offReq = 1'b1, clearReq = 1'b0;
  logic rxReq = 1'b0, txReq = 1'b0, laserFaultDetect = 1'b0, rxPowerLow = 1'b0;
  logic [15:0] diagValue = 16'h0;
  logic [3:0] avs_address = 4'h0, k;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, r, expQ [$];
  wire [31:0] avs_readdata;
  wire avs_waitrequest, laserEnable, rxCdrBypass, txCdrBypass, faultPinOut, faultPinOe;
  wire losPinOut, losPinOe, module_absent_pin, mgmtReady, moduleReady, irq;
  wire laserOffPin, rx_rate_select, tx_rate_select, faultLine, losLine, absentLine;
  integer err_total = 0, samples_checked = 0, n;
  always #25 ref_clk = ~ref_clk;
  sfpc_sideband #(.RESET_CYC(RST_C), .MGMT_CYC(32'h32), .START_CYC(32'h32),
    .HIGH_PWR_CYC(32'h3C), .COOLED_CYC(32'h50), .IDENT_VALUE(ID_VAL)) i_sfpc_sideband (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .laserOffPin(laserOffPin),
    .rx_rate_select(rx_rate_select), .tx_rate_select(tx_rate_select),
    .laserFaultDetect(laserFaultDetect), .rxPowerLow(rxPowerLow), .diagValue(diagValue),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .laserEnable(laserEnable), .rxCdrBypass(rxCdrBypass),
    .txCdrBypass(txCdrBypass), .faultPinOut(faultPinOut), .faultPinOe(faultPinOe),
    .losPinOut(losPinOut), .losPinOe(losPinOe), .module_absent_pin(module_absent_pin),
    .mgmtReady(mgmtReady), .moduleReady(moduleReady), .irq(irq));
  sfpc_host_model #(.HOLD(RST_C + 32'h4)) i_sfpc_host_model (
    .ref_clk(ref_clk), .offReq(offReq), .clearReq(clearReq), .rxReq(rxReq), .txReq(txReq),
    .faultPinOut(faultPinOut), .faultPinOe(faultPinOe), .losPinOut(losPinOut),
    .losPinOe(losPinOe), .module_absent_pin(module_absent_pin), .laserOffPin(laserOffPin),
    .rx_rate_select(rx_rate_select), .tx_rate_select(tx_rate_select),
    .faultLine(faultLine), .losLine(losLine), .absentLine(absentLine));
  wire hotReady;
  // Uncooled build on the same pins and bus, only its ready output is watched
  sfpc_sideband #(.COOLED(0), .RESET_CYC(RST_C), .MGMT_CYC(32'h32), .START_CYC(32'h32),
    .HIGH_PWR_CYC(32'h3C), .COOLED_CYC(32'h50), .IDENT_VALUE(ID_VAL)) i_sfpc_sideband_hot (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .laserOffPin(laserOffPin),
    .rx_rate_select(rx_rate_select), .tx_rate_select(tx_rate_select),
    .laserFaultDetect(laserFaultDetect), .rxPowerLow(rxPowerLow), .diagValue(diagValue),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(), .avs_waitrequest(), .laserEnable(),
    .rxCdrBypass(), .txCdrBypass(), .faultPinOut(), .faultPinOe(), .losPinOut(),
    .losPinOe(), .module_absent_pin(), .mgmtReady(), .moduleReady(hotReady), .irq());
  ////////////////////////////////////////////////////////////////////////////
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task cb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task settle;
    repeat (5) @(negedge ref_clk);
  endtask
  task bus_wait;
    integer w;
    w = 0;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && w < 50) begin
      @(posedge ref_clk);
      w = w + 1;
    end
    if (w >= 50) err_total = err_total + 1;
  endtask
  task bus_rd(input logic [3:0] a, input logic [31:0] e);
    expQ.push_back(e);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= 1'b1;
    bus_wait;
    avs_read <= 1'b0;
  endtask
  task bus_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    bus_wait;
    avs_write <= 1'b0;
  endtask
  task wait_sig(input logic sel);
    integer w;
    w = 0;
    while ((sel ? moduleReady : mgmtReady) !== 1'b1 && w < 200) begin
      @(negedge ref_clk);
      w = w + 1;
    end
    cb(sel ? moduleReady : mgmtReady, 1'b1);
  endtask
  task final_report;
    if (err_total == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Read results leave the queue in request order
  always @(posedge ref_clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) chk(avs_readdata, expQ.pop_front());
  initial begin
    #2000000;
    err_total = err_total + 1;
    final_report;
  end
  initial begin
    void'($urandom(51806));
    repeat (11) @(posedge ref_clk);
    @(negedge ref_clk);
    cb(laserEnable, 1'b0);
    cb(rxCdrBypass, 1'b1);
    cb(irq, 1'b0);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    bus_rd(`SFPC_OFS_IDENT, 32'h0);
    bus_rd(4'hF, 32'h0);
    bus_rd(`SFPC_OFS_IRQ_MASK, 32'h0);
    wait_sig(1'b0);
    cb(hotReady, 1'b1);
    cb(moduleReady, 1'b0);
    r = $urandom;
    @(posedge ref_clk);
    diagValue <= r[15:0];
    bus_rd(`SFPC_OFS_IDENT, ID_VAL);
    bus_rd(`SFPC_OFS_DIAG, {16'h0, r[15:0]});
    wait_sig(1'b1);
    r = $urandom;
    for (n = 0; n < 16; n = n + 1) begin
      k = n[3:0] + r[3:0];
      bus_wr(`SFPC_OFS_CONTROL, {29'h1FFFFFFF, 1'b0, k[1], k[0]});
      @(posedge ref_clk);
      rxReq <= k[2];
      txReq <= k[3];
      settle;
      cb(rxCdrBypass, !((k[2] | k[0]) & (k[3] | k[1])));
      cb(txCdrBypass, !((k[2] | k[0]) & (k[3] | k[1])));
      bus_rd(`SFPC_OFS_CONTROL, {30'h0, k[1], k[0]});
    end
    @(posedge ref_clk);
    offReq <= 1'b0;
    settle;
    cb(laserEnable, 1'b1);
    @(posedge ref_clk);
    offReq <= 1'b1;
    settle;
    cb(laserEnable, 1'b0);
    @(posedge ref_clk);
    offReq <= 1'b0;
    bus_wr(`SFPC_OFS_IRQ_STATUS, 32'hF);
    bus_wr(`SFPC_OFS_IRQ_MASK, 32'h1);
    @(posedge ref_clk);
    laserFaultDetect <= 1'b1;
    repeat (3) @(posedge ref_clk);
    laserFaultDetect <= 1'b0;
    settle;
    cb(faultLine, 1'b1);
    cb(laserEnable, 1'b0);
    cb(irq, 1'b1);
    @(posedge ref_clk);
    offReq <= 1'b1;
    repeat (RST_C / 2) @(posedge ref_clk);
    offReq <= 1'b0;
    settle;
    cb(faultLine, 1'b1);
    @(posedge ref_clk);
    clearReq <= 1'b1;
    @(posedge ref_clk);
    clearReq <= 1'b0;
    repeat (RST_C + 8) @(negedge ref_clk);
    cb(faultLine, 1'b0);
    bus_rd(`SFPC_OFS_IRQ_STATUS, 32'h9);
    bus_wr(`SFPC_OFS_IRQ_MASK, 32'h0);
    settle;
    cb(irq, 1'b0);
    bus_wr(`SFPC_OFS_IRQ_MASK, 32'h8);
    settle;
    cb(irq, 1'b1);
    bus_wr(`SFPC_OFS_IRQ_STATUS, 32'hF);
    settle;
    cb(irq, 1'b0);
    wait_sig(1'b1);
    @(posedge ref_clk);
    rxPowerLow <= 1'b1;
    settle;
    cb(losLine, 1'b1);
    @(posedge ref_clk);
    rxPowerLow <= 1'b0;
    settle;
    cb(losLine, 1'b0);
    cb(absentLine, 1'b0);
    bus_rd(`SFPC_OFS_IRQ_STATUS, 32'h6);
    bus_wr(`SFPC_OFS_CONTROL, 32'h4);
    settle;
    cb(moduleReady, 1'b0);
    cb(hotReady, 1'b0);
    wait_sig(1'b1);
    cb(hotReady, 1'b1);
    bus_rd(`SFPC_OFS_STATUS, {24'h0, 4'hC, k[3] & k[2], k[3], k[2], 1'b0});
    final_report;
  end
endmodule // test_sfpc_sideband
